// ### hdl/rds_block_check.sv
// syndrome check and single bit repair of one 26-bit block
`timescale 1ns/100ps
`default_nettype none
module rds_block_check (
  input  wire logic [25:0]       word,
  input  wire logic              locked,
  input  wire rds_rx_pkg::blk_id_e expect_id,
  output rds_rx_pkg::check_res_s res
);
  import rds_rx_pkg::*;

  function automatic logic [9:0] synd(input logic [25:0] w);
    logic [9:0] r;
    r = '0;
    for (int i = 25; i >= 0; i--) begin
      r = {r[8:0], w[i]} ^ (r[9] ? POLY_LOW : 10'h000);
    end
    return r;
  endfunction

  logic [9:0]  s;
  logic [25:0] fixed;
  logic [9:0]  want;

  always_comb begin
    s = synd(word);
    fixed = word;
    want = OFFSET_WORDS[expect_id == BLK_NONE ? 3'd0 : expect_id];
    res.ok = 1'b0;
    res.corrected = 1'b0;
    res.id = BLK_NONE;
    for (int o = 0; o < 6; o++) begin
      if (!res.ok && s == OFFSET_WORDS[o]) begin
        res.ok = 1'b1;
        res.id = blk_id_e'(o[2:0]);
      end
    end
    // repair only against the flywheel's expected offset, so that a
    // noisy block is not mistaken for another position
    if (!res.ok && locked && expect_id != BLK_NONE) begin // R1
      for (int i = 0; i < 26; i++) begin
        if (!res.ok && (s ^ synd(26'h1 << i)) == want) begin
          res.ok = 1'b1;
          res.corrected = 1'b1;
          res.id = expect_id;
          fixed = word ^ (26'h1 << i);
        end
      end
    end
    res.data = fixed[25:10];
  end
endmodule // rds_block_check
`default_nettype wire

// ### hdl/rds_rx_core.sv
// rds block decoder, flywheel sync, block buffer and pause detector
// Notes on behaviour
// (R1) Each block is checked, repaired when possible, and tracked in sequence.
// (R2) Sync is declared after a programmable run of good blocks, one to fifteen.
// (R3) Acquire and lose counts come from software and steer the flywheel.
// (R4) Up to 126 decoded blocks are held until software reads them.
// (R5) Only blocks that pass the configured filters enter the buffer.
// (R6) Block b is compared with a pattern under a mask and raises an event.
// (R7) A matching program_ident_code in a block raises an event.
// (R8) Audio below a threshold for a set number of samples raises an event.
// (R9) Silence and presence are each declared only after a run of samples.
// (R10) An alternate channel jump request is issued, optionally only in silence.
// (R11) Buffered blocks are read out by software through the data register.
// (R12) Software configures everything through the register interface.
// (R13) Event flags stay set until software writes a one to clear them.
`timescale 1ns/100ps
`default_nettype none
module rds_rx_core #(
  parameter int DEPTH = rds_rx_pkg::BUF_DEPTH
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire rds_rx_pkg::apb_req_s   apb_req,
  output rds_rx_pkg::apb_rsp_s        apb_rsp,
  input  wire rds_rx_pkg::rds_block_s blk_in,
  input  wire rds_rx_pkg::audio_s     audio_in,
  input  wire logic                   alt_better,
  output logic                        irq,
  output logic                        af_jump,
  output logic                        sync_lock,
  output logic                        silence
);
  import rds_rx_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [3:0]        acq;
    logic [3:0]        lose;
    logic [15:0]       bpat;
    logic [15:0]       bmask;
    logic [15:0]       pi;
    logic [15:0]       thr;
    logic [15:0]       dur;
    logic [15:0]       pres;
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   mask;
    logic [31:0]       prdata;
    logic              pslverr;
    sync_state_e       sync;
    logic [3:0]        good_cnt;
    logic [3:0]        bad_cnt;
    blk_id_e           expect_id;
    logic [BUF_AW-1:0] wptr;
    logic [BUF_AW-1:0] rptr;
    logic [BUF_AW-1:0] fill;
    logic              silent;
    logic [15:0]       below_cnt;
    logic [15:0]       above_cnt;
    logic              alt_prev;
    logic              af_jump;
  } state_s;

  localparam state_s STATE_RST = '{
    ctrl: CTRL_RST, acq: ACQ_RST, lose: LOSE_RST, bpat: '0,
    bmask: BMASK_RST, pi: '0, thr: THR_RST, dur: DUR_RST,
    pres: PRES_RST, status: '0, mask: '0, prdata: '0,
    pslverr: 1'b0, sync: SYNC_SEARCH, good_cnt: '0, bad_cnt: '0,
    expect_id: BLK_A, wptr: '0, rptr: '0, fill: '0, silent: 1'b0,
    below_cnt: '0, above_cnt: '0, alt_prev: 1'b0, af_jump: 1'b0};

  localparam logic [BUF_AW-1:0] DEPTH_C = BUF_AW'(DEPTH);

  state_s s_r;
  state_s s_nxt;
  logic [ENTRY_W-1:0] buf_mem [DEPTH];
  check_res_s chk;
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic pop;
  logic push;
  logic blk_go;
  logic good;
  logic in_seq;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] w1c;
  logic [4:0] good_inc;
  logic [4:0] bad_inc;
  logic [16:0] below_inc;
  logic [16:0] above_inc;

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= ADDR_DATA;
  endfunction

  function automatic blk_id_e next_blk(input blk_id_e id);
    unique case (id)
      BLK_A:         return BLK_B;
      BLK_B:         return BLK_C;
      BLK_C, BLK_CP: return BLK_D;
      default:       return BLK_A;
    endcase
  endfunction

  function automatic logic [BUF_AW-1:0] ptr_inc(input logic [BUF_AW-1:0] p);
    return (p == DEPTH_C - 1'b1) ? '0 : p + 1'b1;
  endfunction

  rds_block_check u_check (
    .word      (blk_in.word),
    .locked    (s_r.sync == SYNC_LOCKED),
    .expect_id (s_r.expect_id),
    .res       (chk)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.af_jump = 1'b0;
    ev = '0;
    setup_ph = apb_req.psel && !apb_req.penable;
    access_ph = apb_req.psel && apb_req.penable;
    wr_en = access_ph && apb_req.pwrite && mapped(apb_req.paddr);
    w1c = (wr_en && apb_req.paddr == ADDR_STATUS) ?
          apb_req.pwdata[EV_W-1:0] : '0;
    // pop at the access edge, data was latched at setup
    pop = access_ph && !apb_req.pwrite && apb_req.paddr == ADDR_DATA &&
          s_r.fill != '0; // R11
    // read data is captured in the setup cycle so pready can be constant
    if (setup_ph) begin
      s_nxt.pslverr = !mapped(apb_req.paddr);
      s_nxt.prdata = '0;
      unique case (apb_req.paddr)
        ADDR_CTRL:   s_nxt.prdata[CTRL_W-1:0] = s_r.ctrl;
        ADDR_SYNC:   s_nxt.prdata[11:0] = {s_r.lose, 4'h0, s_r.acq};
        ADDR_BPAT:   s_nxt.prdata[15:0] = s_r.bpat;
        ADDR_BMASK:  s_nxt.prdata[15:0] = s_r.bmask;
        ADDR_PI:     s_nxt.prdata[15:0] = s_r.pi;
        ADDR_THR:    s_nxt.prdata[15:0] = s_r.thr;
        ADDR_DUR:    s_nxt.prdata[15:0] = s_r.dur;
        ADDR_PRES:   s_nxt.prdata[15:0] = s_r.pres;
        ADDR_STATUS: s_nxt.prdata[EV_W-1:0] = s_r.status;
        ADDR_MASK:   s_nxt.prdata[EV_W-1:0] = s_r.mask;
        ADDR_STATE:  s_nxt.prdata[15:0] =
                     {1'b0, s_r.fill, 6'h00, s_r.silent, s_r.sync};
        ADDR_DATA: begin
          s_nxt.prdata[ENTRY_W-1:0] = buf_mem[s_r.rptr]; // R11
          s_nxt.prdata[D_VALID] = s_r.fill != '0;
        end
        default:     s_nxt.prdata = '0;
      endcase
    end
    if (wr_en) begin // R12
      unique case (apb_req.paddr)
        ADDR_CTRL:  s_nxt.ctrl = apb_req.pwdata[CTRL_W-1:0];
        ADDR_SYNC: begin
          s_nxt.acq = apb_req.pwdata[3:0]; // R3
          s_nxt.lose = apb_req.pwdata[11:8]; // R3
        end
        ADDR_BPAT:  s_nxt.bpat = apb_req.pwdata[15:0];
        ADDR_BMASK: s_nxt.bmask = apb_req.pwdata[15:0];
        ADDR_PI:    s_nxt.pi = apb_req.pwdata[15:0];
        ADDR_THR:   s_nxt.thr = apb_req.pwdata[15:0];
        ADDR_DUR:   s_nxt.dur = apb_req.pwdata[15:0];
        ADDR_PRES:  s_nxt.pres = apb_req.pwdata[15:0];
        ADDR_MASK:  s_nxt.mask = apb_req.pwdata[EV_W-1:0];
        default:    s_nxt.mask = s_nxt.mask;
      endcase
    end
    // block decoding and flywheel
    blk_go = blk_in.valid && s_r.ctrl[C_RDS_EN];
    good = chk.ok;
    in_seq = chk.id == s_r.expect_id ||
             (s_r.expect_id == BLK_C && chk.id == BLK_CP);
    good_inc = {1'b0, s_r.good_cnt} + 5'd1;
    bad_inc = {1'b0, s_r.bad_cnt} + 5'd1;
    if (blk_go) begin
      unique case (s_r.sync)
        SYNC_SEARCH: begin
          if (good && chk.id != BLK_E) begin // R1
            s_nxt.good_cnt = (in_seq || s_r.good_cnt == '0) ?
                             (good_inc[4] ? 4'hF : good_inc[3:0]) : 4'h1;
            s_nxt.expect_id = next_blk(chk.id);
            if (good_inc >= {1'b0, s_r.acq} &&
                (in_seq || s_r.good_cnt == '0)) begin // R2
              s_nxt.sync = SYNC_LOCKED;
              s_nxt.bad_cnt = '0;
            end
          end else begin
            s_nxt.good_cnt = '0;
          end
        end
        SYNC_LOCKED: begin
          // flywheel keeps the block position running through bad blocks
          s_nxt.expect_id = next_blk(s_r.expect_id);
          if (good && in_seq) begin
            s_nxt.bad_cnt = '0;
          end else begin
            s_nxt.bad_cnt = bad_inc[4] ? 4'hF : bad_inc[3:0];
            if (bad_inc >= {1'b0, s_r.lose}) begin // R3
              s_nxt.sync = SYNC_SEARCH;
              s_nxt.good_cnt = '0;
              s_nxt.expect_id = BLK_A;
            end
          end
        end
      endcase
    end
    // filtering ahead of the buffer
    push = blk_go && good && !(s_r.ctrl[C_DROP_E] && chk.id == BLK_E) &&
           (!s_r.ctrl[C_NEED_SYNC] || s_r.sync == SYNC_LOCKED) &&
           (!chk.corrected || s_r.ctrl[C_KEEP_CORR]); // R5
    // a full buffer drops the new block and flags it, old data is kept
    if (push && s_r.fill == DEPTH_C && !pop) begin // R4
      push = 1'b0;
      ev[EV_OVF] = 1'b1;
    end
    if (push) begin
      s_nxt.wptr = ptr_inc(s_r.wptr);
    end
    if (pop) begin
      s_nxt.rptr = ptr_inc(s_r.rptr);
    end
    s_nxt.fill = s_r.fill + BUF_AW'(push) - BUF_AW'(pop);
    ev[EV_BMATCH] = blk_go && good && chk.id == BLK_B &&
                    s_r.ctrl[C_BM_EN] &&
                    ((chk.data ^ s_r.bpat) & s_r.bmask) == 16'h0000; // R6
    ev[EV_PI] = blk_go && good && s_r.ctrl[C_PI_EN] &&
                (chk.id == BLK_A || chk.id == BLK_CP) &&
                chk.data == s_r.pi; // R7
    // pause detector with run filters on both transitions
    below_inc = {1'b0, s_r.below_cnt} + 17'd1;
    above_inc = {1'b0, s_r.above_cnt} + 17'd1;
    if (audio_in.valid && s_r.ctrl[C_PAUSE_EN]) begin
      if (audio_in.mag < s_r.thr) begin
        s_nxt.above_cnt = '0; // R9
        if (!s_r.silent) begin
          s_nxt.below_cnt = below_inc[15:0];
          if (below_inc >= {1'b0, s_r.dur}) begin // R8
            s_nxt.silent = 1'b1;
            s_nxt.below_cnt = '0;
            ev[EV_PAUSE] = 1'b1;
          end
        end
      end else begin
        s_nxt.below_cnt = '0; // R9
        if (s_r.silent) begin
          s_nxt.above_cnt = above_inc[15:0];
          if (above_inc >= {1'b0, s_r.pres}) begin // R9
            s_nxt.silent = 1'b0;
            s_nxt.above_cnt = '0;
          end
        end
      end
    end else if (!s_r.ctrl[C_PAUSE_EN]) begin
      s_nxt.silent = 1'b0;
      s_nxt.below_cnt = '0;
      s_nxt.above_cnt = '0;
    end
    // at most one request per rising edge of the better-channel hint
    s_nxt.alt_prev = alt_better;
    s_nxt.af_jump = s_r.ctrl[C_AF_EN] && alt_better && !s_r.alt_prev &&
                    (s_r.silent || !s_r.ctrl[C_AF_SILENT]); // R10
    // set wins over a clear in the same cycle
    s_nxt.status = (s_r.status & ~w1c) | ev; // R13
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // buffer storage has no reset, an empty read still shows the stale entry at rptr with D_VALID clear
  always_ff @(posedge pclk) begin
    if (push) begin
      buf_mem[s_r.wptr] <= {chk.corrected, chk.id, chk.data}; // R4
    end
  end

  assign apb_rsp.prdata = s_r.prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = s_r.pslverr;
  assign irq = |(s_r.status & s_r.mask);
  assign af_jump = s_r.af_jump;
  assign sync_lock = s_r.sync == SYNC_LOCKED;
  assign silence = s_r.silent;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence good_block_s;
    blk_in.valid && s_r.ctrl[C_RDS_EN] && chk.ok;
  endsequence

  sequence quiet_sample_s;
    audio_in.valid && s_r.ctrl[C_PAUSE_EN] && audio_in.mag < s_r.thr;
  endsequence

  a_lock_cause: assert property ($rose(sync_lock) |-> // R2
    $past(blk_in.valid && s_r.ctrl[C_RDS_EN] && chk.ok &&
          {1'b0, s_r.good_cnt} + 5'd1 >= {1'b0, s_r.acq}))
    else $error("sync declared without enough good blocks");
  a_lock_loss: assert property ($fell(sync_lock) |-> // R3
    $past({1'b0, s_r.bad_cnt} + 5'd1 >= {1'b0, s_r.lose}))
    else $error("sync lost before the lose count");
  a_buf_bound: assert property (s_r.fill <= DEPTH_C) // R4
    else $error("buffer fill above depth");
  a_filter_keep: assert property (push |-> chk.ok && // R5
    !(s_r.ctrl[C_DROP_E] && chk.id == BLK_E))
    else $error("filtered block entered buffer");
  a_bmatch_flag: assert property ((good_block_s and // R6
    (chk.id == BLK_B && s_r.ctrl[C_BM_EN] &&
     ((chk.data ^ s_r.bpat) & s_r.bmask) == 16'h0000))
    |=> s_r.status[EV_BMATCH])
    else $error("block b match not flagged");
  a_pi_flag: assert property ((good_block_s and // R7
    (chk.id == BLK_A && s_r.ctrl[C_PI_EN] && chk.data == s_r.pi))
    |=> s_r.status[EV_PI] && (irq || !s_r.mask[EV_PI]))
    else $error("ident match not flagged");
  a_pause_event: assert property ($rose(silence) |-> // R8
    s_r.status[EV_PAUSE] && $past(audio_in.valid && audio_in.mag < s_r.thr))
    else $error("silence without pause event");
  a_quiet_hold: assert property (quiet_sample_s |=> !$fell(silence)) // R9
    else $error("presence declared on a quiet sample");
  a_pause_filter: assert property ($fell(silence) |-> // R9
    $past(audio_in.valid && audio_in.mag >= s_r.thr) ||
    $past(!s_r.ctrl[C_PAUSE_EN]))
    else $error("presence declared without loud sample");
  a_af_silent: assert property (af_jump && $past(s_r.ctrl[C_AF_SILENT]) // R10
    |-> $past(s_r.silent) && !$past(s_r.alt_prev))
    else $error("jump issued outside silence");
  a_pop_order: assert property (pop |=> s_r.rptr == // R11
    ($past(s_r.rptr) == DEPTH_C - 1'b1 ? '0 : $past(s_r.rptr) + 1'b1))
    else $error("read pointer did not advance");
  a_flag_sticky: assert property (s_r.status[EV_PAUSE] && // R13
    !w1c[EV_PAUSE] |=> s_r.status[EV_PAUSE] [*1])
    else $error("pause flag dropped without clear");
endmodule // rds_rx_core
`default_nettype wire

// ### include/rds_rx_pkg.sv
// shared constants and carriers for the rds receive block
package rds_rx_pkg;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_SYNC   = 8'h04;
  localparam logic [7:0] ADDR_BPAT   = 8'h08;
  localparam logic [7:0] ADDR_BMASK  = 8'h0C;
  localparam logic [7:0] ADDR_PI     = 8'h10;
  localparam logic [7:0] ADDR_THR    = 8'h14;
  localparam logic [7:0] ADDR_DUR    = 8'h18;
  localparam logic [7:0] ADDR_PRES   = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_MASK   = 8'h24;
  localparam logic [7:0] ADDR_STATE  = 8'h28;
  localparam logic [7:0] ADDR_DATA   = 8'h2C;
  // control bits
  localparam int C_RDS_EN    = 0;
  localparam int C_KEEP_CORR = 1;
  localparam int C_DROP_E    = 2;
  localparam int C_NEED_SYNC = 3;
  localparam int C_BM_EN     = 4;
  localparam int C_PI_EN     = 5;
  localparam int C_PAUSE_EN  = 6;
  localparam int C_AF_EN     = 7;
  localparam int C_AF_SILENT = 8;
  localparam int CTRL_W      = 9;
  // event bits of status and mask
  localparam int EV_BMATCH = 0;
  localparam int EV_PI     = 1;
  localparam int EV_PAUSE  = 2;
  localparam int EV_OVF    = 3;
  localparam int EV_W      = 4;
  // data word fields
  localparam int D_ID_LO   = 16;
  localparam int D_CORR    = 19;
  localparam int D_VALID   = 31;
  localparam int ENTRY_W   = 20;
  // reset values
  localparam logic [8:0]  CTRL_RST  = 9'h000;
  localparam logic [3:0]  ACQ_RST   = 4'h2;
  localparam logic [3:0]  LOSE_RST  = 4'h4;
  localparam logic [15:0] BMASK_RST = 16'hFFFF;
  localparam logic [15:0] THR_RST   = 16'h0100;
  localparam logic [15:0] DUR_RST   = 16'h0800;
  localparam logic [15:0] PRES_RST  = 16'h0040;
  localparam int BUF_DEPTH = 126;
  localparam int BUF_AW    = 7;
  // check polynomial without its top term, and offset words a..e
  localparam logic [9:0] POLY_LOW = 10'h1B9;
  localparam logic [5:0][9:0] OFFSET_WORDS =
    {10'h000, 10'h1B4, 10'h350, 10'h168, 10'h198, 10'h0FC};
  typedef enum logic [2:0] {
    BLK_A, BLK_B, BLK_C, BLK_CP, BLK_D, BLK_E, BLK_NONE
  } blk_id_e;
  typedef enum logic [0:0] {SYNC_SEARCH, SYNC_LOCKED} sync_state_e;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;
  typedef struct packed {
    logic        valid;
    logic [25:0] word;
  } rds_block_s;
  typedef struct packed {
    logic        valid;
    logic [15:0] mag;
  } audio_s;
  typedef struct packed {
    logic        ok;
    logic        corrected;
    blk_id_e     id;
    logic [15:0] data;
  } check_res_s;
endpackage

// ### testbench/rds_src_model.sv
// block source model: encodes checkword and offset for each sent block
`timescale 1ns/100ps
`default_nettype none
module rds_src_model (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                snd,
  input  wire logic [15:0]         sdata,
  input  wire rds_rx_pkg::blk_id_e sid,
  input  wire logic [25:0]         flip,
  output rds_rx_pkg::rds_block_s   blk
);
  import rds_rx_pkg::*;
  logic [9:0]  crc;
  logic [25:0] code;
  // checkword is data times x^10 modulo the generator, then offset added
  always_comb begin
    crc = 10'h000;
    for (int i = 15; i >= 0; i--) begin
      if (crc[9] ^ sdata[i]) begin
        crc = {crc[8:0], 1'b0} ^ POLY_LOW;
      end else begin
        crc = {crc[8:0], 1'b0};
      end
    end
    code = {sdata, crc ^ OFFSET_WORDS[sid]} ^ flip;
  end
  // idle word toggles so a stale block never looks valid by accident
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk <= '0;
    end else begin
      blk.valid <= snd;
      blk.word  <= snd ? code : ~blk.word;
    end
  end
endmodule // rds_src_model
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the rds receive core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rds_rx_pkg::*;
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  apb_req_s    req        = '0;
  apb_rsp_s    rsp;
  rds_block_s  blk;
  audio_s      aud        = '0;
  logic        alt_better = 1'b0;
  logic        irq;
  logic        af_jump;
  logic        sync_lock;
  logic        silence;
  logic        snd        = 1'b0;
  logic [15:0] sdata      = 16'h0000;
  blk_id_e     sid        = BLK_A;
  logic [25:0] flip       = 26'h0;
  int          err_total  = 0;
  int          tests_run  = 0;
  int          af_seen    = 0;
  logic [31:0] rd;
  logic        rerr;
  blk_id_e     ids [4]    = '{BLK_A, BLK_B, BLK_C, BLK_D};

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (af_jump === 1'b1) af_seen++;
  end

  rds_src_model src_u (.pclk(pclk), .presetn(presetn), .snd(snd),
    .sdata(sdata), .sid(sid), .flip(flip), .blk(blk));
  rds_rx_core dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .blk_in(blk), .audio_in(aud),
    .alt_better(alt_better), .irq(irq), .af_jump(af_jump),
    .sync_lock(sync_lock), .silence(silence));

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  task automatic send(input blk_id_e id, input logic [15:0] d,
                      input logic [25:0] f);
    @(posedge pclk);
    snd <= 1'b1;
    sid <= id;
    sdata <= d;
    flip <= f;
    @(posedge pclk);
    snd <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic sample(input logic [15:0] m);
    @(posedge pclk);
    aud <= '{valid:1'b1, mag:m};
    @(posedge pclk);
    aud.valid <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic t_reset();
    logic [7:0]  ra [10] = '{ADDR_CTRL, ADDR_SYNC, ADDR_BPAT, ADDR_BMASK,
      ADDR_PI, ADDR_THR, ADDR_DUR, ADDR_PRES, ADDR_STATUS, ADDR_MASK};
    logic [31:0] rv [10] = '{32'h0, 32'h0402, 32'h0, 32'hFFFF, 32'h0,
      32'h0100, 32'h0800, 32'h0040, 32'h0, 32'h0};
    for (int i = 0; i < 10; i++) rchk("reset value", ra[i], rv[i]);
    xfer(1'b0, 8'h30, 32'h0);
    chk("unmapped err", 32'h1, 32'(rerr));
    chk("unmapped data", 32'h0, rd);
    xfer(1'b1, 8'h06, 32'h0);
    chk("unaligned err", 32'h1, 32'(rerr));
    xfer(1'b1, ADDR_STATE, 32'hFFFF);
    chk("state write err", 32'h0, 32'(rerr));
    rchk("state read only", ADDR_STATE, 32'h0);
  endtask

  task automatic t_sync();
    xfer(1'b1, ADDR_SYNC, 32'h0202);
    xfer(1'b1, ADDR_CTRL, 32'h0003);
    send(BLK_A, 16'h1111, 26'h0);
    chk("lock one", 32'h0, 32'(sync_lock));
    send(BLK_B, 16'h2222, 26'h0);
    chk("lock two", 32'h1, 32'(sync_lock));
    send(BLK_C, 16'h3333, 26'h4000);
    send(BLK_D, 16'h4444, 26'h3);
    chk("lock one bad", 32'h1, 32'(sync_lock));
    send(BLK_A, 16'h5555, 26'h3);
    chk("lock lost", 32'h0, 32'(sync_lock));
    rchk("fill", ADDR_STATE, 32'h0300);
    rchk("data a", ADDR_DATA, 32'h8000_1111);
    rchk("data b", ADDR_DATA, 32'h8001_2222);
    rchk("repaired c", ADDR_DATA, 32'h800A_3333);
    xfer(1'b0, ADDR_DATA, 32'h0);
    chk("empty valid", 32'h0, 32'(rd[D_VALID]));
  endtask

  task automatic t_match();
    xfer(1'b1, ADDR_BPAT, 32'h1234);
    xfer(1'b1, ADDR_BMASK, 32'hFF00);
    xfer(1'b1, ADDR_PI, 32'hBEEF);
    xfer(1'b1, ADDR_MASK, 32'h3);
    xfer(1'b1, ADDR_CTRL, 32'h0035);
    send(BLK_B, 16'h13AB, 26'h0);
    rchk("no match", ADDR_STATUS, 32'h0);
    chk("irq idle", 32'h0, 32'(irq));
    send(BLK_B, 16'h12AB, 26'h0);
    rchk("b match", ADDR_STATUS, 32'h1);
    chk("irq b", 32'h1, 32'(irq));
    send(BLK_A, 16'hBEEF, 26'h0);
    rchk("ident", ADDR_STATUS, 32'h3);
    xfer(1'b1, ADDR_STATUS, 32'h1);
    rchk("clear one", ADDR_STATUS, 32'h2);
    xfer(1'b1, ADDR_MASK, 32'h1);
    // irq is built from registers that update at the access edge
    @(posedge pclk);
    chk("irq masked", 32'h0, 32'(irq));
    xfer(1'b1, ADDR_STATUS, 32'h2);
    rchk("clear two", ADDR_STATUS, 32'h0);
    send(BLK_E, 16'h7777, 26'h0);
    rchk("e dropped", ADDR_STATE, 32'h0300);
    rchk("first kept", ADDR_DATA, 32'h8001_13AB);
    repeat (2) xfer(1'b0, ADDR_DATA, 32'h0);
  endtask

  task automatic t_pause();
    xfer(1'b1, ADDR_DUR, 32'h3);
    xfer(1'b1, ADDR_PRES, 32'h2);
    xfer(1'b1, ADDR_MASK, 32'h4);
    xfer(1'b1, ADDR_CTRL, 32'h01C0);
    @(posedge pclk);
    alt_better <= 1'b1;
    repeat (3) @(posedge pclk);
    alt_better <= 1'b0;
    chk("no jump loud", 32'h0, 32'(af_seen));
    sample(16'h00FF);
    sample(16'h00FF);
    sample(16'h0100);
    sample(16'h00FF);
    sample(16'h00FF);
    chk("quiet run cut", 32'h0, 32'(silence));
    sample(16'h00FF);
    chk("silent", 32'h1, 32'(silence));
    rchk("pause event", ADDR_STATUS, 32'h4);
    chk("irq pause", 32'h1, 32'(irq));
    rchk("state silent", ADDR_STATE, 32'h0002);
    @(posedge pclk);
    alt_better <= 1'b1;
    repeat (3) @(posedge pclk);
    alt_better <= 1'b0;
    chk("one jump", 32'h1, 32'(af_seen));
    sample(16'h0100);
    chk("still silent", 32'h1, 32'(silence));
    sample(16'h0100);
    chk("presence", 32'h0, 32'(silence));
    rchk("no presence event", ADDR_STATUS, 32'h4);
    xfer(1'b1, ADDR_STATUS, 32'h4);
    @(posedge pclk);
    chk("irq cleared", 32'h0, 32'(irq));
  endtask

  task automatic t_ovf();
    xfer(1'b1, ADDR_MASK, 32'h8);
    xfer(1'b1, ADDR_CTRL, 32'h0001);
    for (int i = 0; i < 127; i++) send(ids[i % 4], 16'(i), 26'h0);
    rchk("full", ADDR_STATE, 32'h7E01);
    rchk("overflow", ADDR_STATUS, 32'h8);
    for (int i = 0; i < 126; i++) begin
      rchk("drain", ADDR_DATA, {1'b1, 11'h000, 1'b0,
        3'(ids[i % 4]), 16'(i)});
    end
    xfer(1'b0, ADDR_DATA, 32'h0);
    chk("drained", 32'h0, 32'(rd[D_VALID]));
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // whole run needs a little over a thousand cycles; this bound only cuts a hang
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sync();
    t_match();
    t_pause();
    t_ovf();
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
